// ===== logic/sfp_cfg.svh
// Purpose: Constants of the serial ferroelectric memory command and protect block.
// Assumes: Included by bare name; definitions only.
// Notes: Opcodes, status layout, protected ranges and frame bit counts.
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

`define SFP_OP_LATCH_SET 8'h06
`define SFP_OP_LATCH_CLR 8'h04
`define SFP_OP_STAT_RD   8'h05
`define SFP_OP_STAT_WR   8'h01
`define SFP_OP_MEM_RD    8'h03
`define SFP_OP_FAST_RD   8'h0b
`define SFP_OP_MEM_WR    8'h02
`define SFP_OP_SLEEP     8'hb9
`define SFP_OP_IDENT     8'h9f

`define SFP_SR_PGE       7
`define SFP_SR_ONE       6
`define SFP_SR_BGH       3
`define SFP_SR_BGL       2
`define SFP_SR_WLF       1
`define SFP_SR_FIXED     8'h40
`define SFP_NV_FACTORY   3'h0

`define SFP_ADDR_W       18
`define SFP_QUARTER_BASE 18'h30000
`define SFP_HALF_BASE    18'h20000

`define SFP_OP_BITS      5'h08
`define SFP_WR_BITS      5'h10
`define SFP_SYNC_IDLE    4'hc
`define SFP_SY_CS        3
`define SFP_SY_WP        2
`define SFP_SY_OP        1
`define SFP_SY_WR        0

`endif

// ===== logic/sfp_pkg.sv
// Purpose: Types shared by the command and protect block.
// Assumes: Nothing beyond the constants header.
// Notes: The command code is what the array sequencer acts on.
package sfp_pkg;
    typedef enum logic [3:0] {
        sfp_cmd_none,
        sfp_cmd_latch_set,
        sfp_cmd_latch_clear,
        sfp_cmd_status_read,
        sfp_cmd_status_write,
        sfp_cmd_mem_read,
        sfp_cmd_fast_read,
        sfp_cmd_mem_write,
        sfp_cmd_sleep,
        sfp_cmd_identity_read,
        sfp_cmd_bad
    } sfp_cmd_type;
endpackage

// ===== logic/sfp_command_protect.sv
// Purpose: Opcode decode, status register and write protection of the memory slave.
// Assumes: sck is the link clock; clk is the host clock; frames end on cs_n high.
// Notes: Guard bits are restored from nv_restore after reset and saved on change.
`timescale 1ns/10ps
`include "sfp_cfg.svh"

module sfp_command_protect
    import sfp_pkg::*;
(
    // Host clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Serial link pins
    input  wire logic                    sck,
    input  wire logic                    cs_n,
    input  wire logic                    si,
    output logic                         so,
    output logic                         so_oe,
    input  wire logic                    wp_n,
    // Nonvolatile backing of the guard bits
    input  wire logic [2:0]              nv_restore,
    output logic      [2:0]              nv_save,
    output logic                         nv_save_we,
    // Array sequencer side
    output sfp_cmd_type                  cmd_code,
    output logic                         cmd_valid,
    input  wire logic [`SFP_ADDR_W-1:0]  mem_addr,
    output logic                         mem_write_ok,
    output logic      [7:0]              protection_status
);

    // Link domain state, cleared by the frame's own chip select except snap1 and snap2. Only rising
    // edges are counted, so a frame that opens with the clock high needs no
    // mode detection: its first falling edge finds op_done low and does nothing.
    logic [4:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] op_byte;
    logic       op_done;
    logic [7:0] wr_byte;
    logic       wr_done;
    logic [7:0] snap1;
    logic [7:0] snap2;
    logic [7:0] so_sh;
    logic       so_ld;

    // Host domain state.
    logic [3:0]  sy1;
    logic [3:0]  sy2;
    logic [3:0]  sy3;
    logic        op_rise;
    logic        wr_rise;
    logic        cs_rise;
    logic        cs_fall;
    logic        wp_low;
    sfp_cmd_type cur_cmd;
    sfp_cmd_type next_cmd;
    logic        write_latch_flag;
    logic        pin_guard_enable;
    logic        block_guard_hi;
    logic        block_guard_lo;
    logic        restore_pend;
    logic        sr_write_ok;

    function automatic sfp_cmd_type decode_op(input logic [7:0] op);
        sfp_cmd_type c;
        c = sfp_cmd_bad;
        unique case (op)
            `SFP_OP_LATCH_SET: begin
                c = sfp_cmd_latch_set;
            end
            `SFP_OP_LATCH_CLR: begin
                c = sfp_cmd_latch_clear;
            end
            `SFP_OP_STAT_RD: begin
                c = sfp_cmd_status_read;
            end
            `SFP_OP_STAT_WR: begin
                c = sfp_cmd_status_write;
            end
            `SFP_OP_MEM_RD: begin
                c = sfp_cmd_mem_read;
            end
            `SFP_OP_FAST_RD: begin
                c = sfp_cmd_fast_read;
            end
            `SFP_OP_MEM_WR: begin
                c = sfp_cmd_mem_write;
            end
            `SFP_OP_SLEEP: begin
                c = sfp_cmd_sleep;
            end
            `SFP_OP_IDENT: begin
                c = sfp_cmd_identity_read;
            end
            default: begin
                c = sfp_cmd_bad;
            end
        endcase
        return c;
    endfunction

    function automatic logic addr_guarded(
        input logic [`SFP_ADDR_W-1:0] a,
        input logic                   hi,
        input logic                   lo
    );
        logic g;
        g = 1'b0;
        unique case ({hi, lo})
            2'b00: begin
                g = 1'b0;
            end
            2'b01: begin
                g = (a >= `SFP_QUARTER_BASE);
            end
            2'b10: begin
                g = (a >= `SFP_HALF_BASE);
            end
            2'b11: begin
                g = 1'b1;
            end
        endcase
        return g;
    endfunction

    // Commands that drop the latch when their frame ends, whether or not the
    // write they carried was allowed to land.
    function automatic logic frame_clears_latch(input sfp_cmd_type c);
        logic f;
        f = 1'b0;
        unique case (c)
            sfp_cmd_latch_clear, sfp_cmd_status_write, sfp_cmd_mem_write: begin
                f = 1'b1;
            end
            default: begin
                f = 1'b0;
            end
        endcase
        return f;
    endfunction

    // The fixed bits come from a constant and the latch flag from the latch
    // itself, so no bit position of a status write can ever reach them.
    function automatic logic [7:0] pack_status(
        input logic pge,
        input logic bgh,
        input logic bgl,
        input logic wlf
    );
        logic [7:0] s;
        s              = `SFP_SR_FIXED;
        s[`SFP_SR_PGE] = pge;
        s[`SFP_SR_BGH] = bgh;
        s[`SFP_SR_BGL] = bgl;
        s[`SFP_SR_WLF] = wlf;
        return s;
    endfunction

    // Bit counter saturates once a status write frame is complete.
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt <= 5'h00;
        end else if (bit_cnt != `SFP_WR_BITS) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // The captures below append si directly, so each byte is whole at the
    // very edge of its last bit rather than one edge later.
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            shift_in <= 8'h00;
        end else begin
            shift_in <= {shift_in[6:0], si};
        end
    end

    // Only the first byte of a frame is taken as an opcode.
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            op_byte <= 8'h00;
            op_done <= 1'b0;
        end else if (!op_done && bit_cnt == `SFP_OP_BITS - 5'h01) begin
            op_byte <= {shift_in[6:0], si};
            op_done <= 1'b1;
        end
    end

    // A short status write frame never raises wr_done, so nothing is loaded.
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            wr_byte <= 8'h00;
            wr_done <= 1'b0;
        end else if (op_done && decode_op(op_byte) == sfp_cmd_status_write
                     && bit_cnt == `SFP_WR_BITS - 5'h01) begin
            wr_byte <= {shift_in[6:0], si};
            wr_done <= 1'b1;
        end
    end

    // A status read frame never changes the status word, so two link edges settle it
    // long before the first output bit is needed.
    always_ff @(posedge sck) begin
        snap1 <= protection_status;
        snap2 <= snap1;
    end

    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so_sh <= 8'h00;
            so_ld <= 1'b0;
        end else if (op_done && decode_op(op_byte) == sfp_cmd_status_read) begin
            if (!so_ld) begin
                so_sh <= snap2;
            end else begin
                so_sh <= {so_sh[6:0], 1'b0};
            end
            so_ld <= 1'b1;
        end
    end

    assign so = so_sh[7];
    // Output stays off for every opcode but status read, so a refused opcode
    // leaves a shared data line free for the rest of its frame.
    assign so_oe = !cs_n && so_ld;

    // Two-stage synchronisers for pins and link levels; third stage for edges.
    // The price is latency: a command acts two to three host clocks after its
    // last link edge, so a frame must stay selected at least that long.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sy1 <= `SFP_SYNC_IDLE;
            sy2 <= `SFP_SYNC_IDLE;
            sy3 <= `SFP_SYNC_IDLE;
        end else begin
            sy1 <= {cs_n, wp_n, op_done, wr_done};
            sy2 <= sy1;
            sy3 <= sy2;
        end
    end

    assign op_rise = sy2[`SFP_SY_OP] && !sy3[`SFP_SY_OP];
    assign wr_rise = sy2[`SFP_SY_WR] && !sy3[`SFP_SY_WR];
    assign cs_rise = sy2[`SFP_SY_CS] && !sy3[`SFP_SY_CS];
    assign cs_fall = !sy2[`SFP_SY_CS] && sy3[`SFP_SY_CS];
    assign wp_low  = !sy2[`SFP_SY_WP];

    // The opcode byte is stable once op_done is seen, as it holds until cs_n rises.
    // A new frame forgets the old command before its own opcode is whole, so
    // the sequencer never acts on a stale code.
    always_comb begin
        next_cmd = cur_cmd;
        if (cs_fall) begin
            next_cmd = sfp_cmd_none;
        end else if (op_rise) begin
            next_cmd = decode_op(op_byte);
        end
    end

    // cmd_valid marks the one cycle in which cmd_code takes a new opcode.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur_cmd   <= sfp_cmd_none;
            cmd_valid <= 1'b0;
        end else begin
            cur_cmd   <= next_cmd;
            cmd_valid <= op_rise;
        end
    end

    assign cmd_code = cur_cmd;

    // Opcode actions take priority over the frame-end clear. The two never meet
    // in one cycle, as a frame ends long before the next opcode is whole.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            write_latch_flag <= 1'b0;
        end else if (op_rise && next_cmd == sfp_cmd_latch_set) begin
            write_latch_flag <= 1'b1;
        end else if (op_rise && next_cmd == sfp_cmd_latch_clear) begin
            write_latch_flag <= 1'b0;
        end else if (cs_rise && frame_clears_latch(cur_cmd)) begin
            write_latch_flag <= 1'b0;
        end
    end

    // Writing the status needs the latch, and the pin only when guarded.
    // A refused status write still ends as a status write and clears the latch.
    assign sr_write_ok = write_latch_flag
                         && !(pin_guard_enable && wp_low);

    // Guard bits start at the factory value and take the saved copy once
    // reset is released, modelling their retention over power loss.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {pin_guard_enable, block_guard_hi, block_guard_lo} <= `SFP_NV_FACTORY;
            restore_pend <= 1'b1;
        end else if (restore_pend) begin
            {pin_guard_enable, block_guard_hi, block_guard_lo} <= nv_restore;
            restore_pend <= 1'b0;
        end else if (wr_rise && cur_cmd == sfp_cmd_status_write && sr_write_ok) begin
            pin_guard_enable <= wr_byte[`SFP_SR_PGE];
            block_guard_hi   <= wr_byte[`SFP_SR_BGH];
            block_guard_lo   <= wr_byte[`SFP_SR_BGL];
        end
    end

    // The restored value is copied straight in, so leaving reset never strobes
    // a save of the very bits that were just read back.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nv_save    <= `SFP_NV_FACTORY;
            nv_save_we <= 1'b0;
        end else if (restore_pend) begin
            nv_save    <= nv_restore;
            nv_save_we <= 1'b0;
        end else begin
            nv_save    <= {pin_guard_enable, block_guard_hi, block_guard_lo};
            nv_save_we <= !restore_pend && (nv_save
                          != {pin_guard_enable, block_guard_hi, block_guard_lo});
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            protection_status <= `SFP_SR_FIXED;
        end else begin
            protection_status <= pack_status(pin_guard_enable, block_guard_hi,
                                             block_guard_lo, write_latch_flag);
        end
    end

    // Evaluated every cycle for whatever address the sequencer presents, so a
    // burst write of any length never waits on this block.
    // The write-protect pin is deliberately absent from this term.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_write_ok <= 1'b0;
        end else begin
            mem_write_ok <= write_latch_flag
                            && !addr_guarded(mem_addr, block_guard_hi, block_guard_lo);
        end
    end

endmodule

// ===== testbench/sfp_command_protect_monitor.sv
// Purpose: Port assertions of the command and protect block.
// Assumes: All checks run on the host clock.
// Notes: The status word lags the internal latch by one clk.
`timescale 1ns/10ps
`include "sfp_cfg.svh"
module sfp_command_protect_monitor
    import sfp_pkg::*;
(
    // Clock, reset and pins
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cs_n,
    input wire logic        so_oe,
    input wire logic        wp_n,
    // Status and array side
    input wire logic [2:0]  nv_save,
    input wire logic        nv_save_we,
    input wire sfp_cmd_type cmd_code,
    input wire logic        cmd_valid,
    input wire logic [17:0] mem_addr,
    input wire logic        mem_write_ok,
    input wire logic [7:0]  protection_status
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    function automatic logic hit(logic [17:0] a, logic [1:0] c);
        return c == 2'h3 || (c == 2'h2 && a >= `SFP_HALF_BASE) || (c == 2'h1 && a >= `SFP_QUARTER_BASE);
    endfunction
    // The pin must be seen low long enough to pass the synchroniser.
    sequence s_pin_low;
        !wp_n [*6];
    endsequence
    a_fixed_bits: assert property ((protection_status & 8'h71) == 8'h40)
        else $error("fixed status bits wrong");
    a_write_gate: assert property ($past(rst_n) |-> mem_write_ok ==
        (protection_status[1] && !hit($past(mem_addr), protection_status[3:2])))
        else $error("write permission wrong");
    a_select_oe: assert property (so_oe |-> !cs_n)
        else $error("output driven while deselected");
    a_bad_quiet: assert property (cmd_code == sfp_cmd_bad |-> !so_oe)
        else $error("output driven after refused opcode");
    a_valid_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("command pulse too long");
    a_valid_code: assert property (cmd_valid |-> cmd_code != sfp_cmd_none)
        else $error("command pulse without code");
    a_save_copy: assert property ($past(rst_n, 2) |->
        nv_save == {protection_status[7], protection_status[3:2]})
        else $error("saved bits differ from status");
    a_save_pulse: assert property ($past(rst_n, 3) && $changed(nv_save) |-> ##[0:1] nv_save_we)
        else $error("saved bits changed without strobe");
    a_pin_guard: assert property (s_pin_low ##0 protection_status[7] |=>
        $stable(protection_status[3:2]) && protection_status[7])
        else $error("status changed while pin guarded");
endmodule
bind sfp_command_protect sfp_command_protect_monitor u_sfp_command_protect_monitor (
    .clk, .rst_n, .cs_n, .so_oe, .wp_n, .nv_save, .nv_save_we,
    .cmd_code, .cmd_valid, .mem_addr, .mem_write_ok, .protection_status);

// ===== testbench/sfp_spi_master.sv
// Purpose: Mode 0 serial master on the link pins.
// Assumes: Used only after reset release.
// Notes: Data is inverted between frames so a stale bit never looks valid.
`timescale 1ns/10ps
module sfp_spi_master (
    // Link pins
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // Sends the top n bits of tx; bits 9 to 16 seen on so fill rx.
    task automatic xfer(input logic [15:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        #5 cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            #40 si = tx[15 - i];
            #40 sck = 1'b1;
            if (i >= 8) rx = {rx[6:0], so_oe ? so : 1'bx};
            #80 sck = 1'b0;
        end
        #80 cs_n = 1'b1;
        si = ~si;
        #80;
    endtask
endmodule

// ===== testbench/sfp_command_protect_test.sv
// Purpose: Self-checking bench of the command and protect block.
// Assumes: Master model makes the link clock.
// Notes: Status is read back over the link after every change except the 8'h80 write, some latch sets, the opcode sweep and the restore.
`timescale 1ns/10ps
module sfp_command_protect_test;
    import sfp_pkg::*;
    logic        clk, rst_n, sck, cs_n, si, so, so_oe, wp_n;
    logic        nv_save_we, cmd_valid, mem_write_ok;
    logic [2:0]  nv_restore, nv_save;
    logic [17:0] mem_addr;
    logic [7:0]  protection_status, rx;
    sfp_cmd_type cmd_code;
    int          fail_count = 0;
    int          checked = 0;
    logic [7:0]  ops [10] = '{8'h03, 8'h0b, 8'h02, 8'h9f, 8'h06, 8'h04, 8'h05, 8'h01, 8'hff, 8'hb9};
    sfp_cmd_type codes [10] = '{sfp_cmd_mem_read, sfp_cmd_fast_read, sfp_cmd_mem_write,
        sfp_cmd_identity_read, sfp_cmd_latch_set, sfp_cmd_latch_clear, sfp_cmd_status_read,
        sfp_cmd_status_write, sfp_cmd_bad, sfp_cmd_sleep};
    logic [17:0] addrs [6] = '{18'h00000, 18'h1ffff, 18'h20000, 18'h2ffff, 18'h30000, 18'h3ffff};
    always #4 clk = ~clk;
    sfp_command_protect u_sfp_command_protect (.clk, .rst_n, .sck, .cs_n, .si, .so, .so_oe, .wp_n,
        .nv_restore, .nv_save, .nv_save_we, .cmd_code, .cmd_valid, .mem_addr, .mem_write_ok,
        .protection_status);
    sfp_spi_master u_sfp_spi_master (.sck, .cs_n, .si, .so, .so_oe);
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic frame(logic [15:0] tx, int n);
        u_sfp_spi_master.xfer(tx, n, rx);
        repeat (4) @(negedge clk);
    endtask
    task automatic rd_status(logic [7:0] exp);
        frame(16'h0500, 16);
        check("status", rx, exp);
    endtask
    task automatic wr_status(logic [7:0] d);
        frame(16'h0600, 8);
        frame({8'h01, d}, 16);
    endtask
    task automatic chk_ok(logic [17:0] a, logic exp);
        mem_addr = a;
        repeat (2) @(negedge clk);
        check("write_ok", {7'h00, mem_write_ok}, {7'h00, exp});
    endtask
    function automatic logic free(logic [17:0] a, int c);
        return c == 0 || (c == 1 && a < 18'h30000) || (c == 2 && a < 18'h20000);
    endfunction
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        wp_n = 1'b1;
        nv_restore = 3'h0;
        mem_addr = 18'h00000;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check("reset", protection_status, 8'h40);
        rd_status(8'h40);
        frame(16'h01ff, 16);
        rd_status(8'h40);
        frame(16'h0600, 8);
        rd_status(8'h42);
        frame(16'h01ff, 12);
        frame(16'h0500, 16);
        check("status", rx | 8'h02, 8'h42);
        wr_status(8'hff);
        rd_status(8'hcc);
        check("nv", {5'h00, nv_save}, 8'h07);
        for (int c = 0; c < 4; c++) begin
            wr_status(8'(c << 2));
            frame(16'h0600, 8);
            rd_status(8'h42 | 8'(c << 2));
            foreach (addrs[j]) chk_ok(addrs[j], free(addrs[j], c));
        end
        wr_status(8'h80);
        wp_n = 1'b0;
        wr_status(8'h0c);
        frame(16'h0500, 16);
        check("status", rx & 8'hfd, 8'hc0);
        frame(16'h0600, 8);
        chk_ok(18'h3ffff, 1'b1);
        wp_n = 1'b1;
        wr_status(8'h00);
        frame(16'h0600, 8);
        frame(16'h0400, 8);
        rd_status(8'h40);
        chk_ok(18'h00000, 1'b0);
        frame(16'h0600, 8);
        frame(16'h0200, 16);
        rd_status(8'h40);
        foreach (ops[i]) begin
            frame({ops[i], 8'h00}, 8);
            check("cmd", {4'h0, cmd_code}, {4'h0, codes[i]});
        end
        nv_restore = 3'h5;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check("restore", protection_status, 8'hc4);
        check("nv", {5'h00, nv_save}, 8'h05);
        end_of_test();
    end
    initial begin
        #400000;
        fail_count++;
        end_of_test();
    end
endmodule
